// file: maw_pkg.sv
package maw_pkg;

  // counts of regions, events and subregions
  localparam int USER_NUM = 4;
  localparam int PER_NUM  = 2;
  localparam int SUB_NUM  = 32;
  localparam int EV_NUM   = 2 * (USER_NUM + PER_NUM);
  localparam int EV_PER_BASE = 2 * USER_NUM;

  // register byte offsets on the avalon slave
  localparam logic [11:0] OFS_EV_USER     = 12'h100;
  localparam logic [11:0] OFS_EV_PER      = 12'h160;
  localparam logic [11:0] OFS_INTEN       = 12'h300;
  localparam logic [11:0] OFS_INTEN_SET   = 12'h304;
  localparam logic [11:0] OFS_INTEN_CLR   = 12'h308;
  localparam logic [11:0] OFS_NMIEN       = 12'h320;
  localparam logic [11:0] OFS_NMIEN_SET   = 12'h324;
  localparam logic [11:0] OFS_NMIEN_CLR   = 12'h328;
  localparam logic [11:0] OFS_SUBSTAT     = 12'h400;
  localparam logic [11:0] OFS_WEN         = 12'h510;
  localparam logic [11:0] OFS_WEN_SET     = 12'h514;
  localparam logic [11:0] OFS_WEN_CLR     = 12'h518;
  localparam logic [11:0] OFS_USER_START  = 12'h600;
  localparam logic [11:0] OFS_PER_CFG     = 12'h6c0;
  localparam logic [11:0] REGION_STRIDE   = 12'h010;
  localparam logic [11:0] END_DELTA       = 12'h004;
  localparam logic [11:0] SUBREGION_INCLUDE_MASK_DELTA      = 12'h008;
  localparam logic [11:0] EV_STRIDE       = 12'h004;

  // field positions inside the watch enable mask
  localparam int WEN_PER_LSB = 24;
  localparam logic [31:0] WEN_MASK = 32'h0f0000ff;

  // values after reset
  localparam logic [31:0] ADDR_RESET = 32'h00000000;
  localparam logic [31:0] WEN_RESET  = 32'h00000000;
  localparam logic [31:0] SUBREGION_INCLUDE_MASK_RESET = 32'h00000000;

  // fixed peripheral watch regions
  localparam logic [31:0] PER_FIRST [PER_NUM] = '{32'h40000000, 32'h40020000};
  localparam logic [31:0] PER_LAST  [PER_NUM] = '{32'h4001ffff, 32'h4003ffff};
  localparam int SUB_LSB = 12;
  localparam int SUB_IDX_W = 5;

  // watched memory segments
  localparam logic [31:0] RAM_SEG_FIRST = 32'h20000000;
  localparam logic [31:0] RAM_SEG_LAST  = 32'h3fffffff;
  localparam logic [31:0] PER_SEG_FIRST = 32'h40000000;
  localparam logic [31:0] PER_SEG_LAST  = 32'h5fffffff;

endpackage : maw_pkg

// file: maw_hit_if.sv
`timescale 1ns/10ps
interface maw_hit_if import maw_pkg::*; ();

  // snooped access, one cycle after the cpu issued it
  logic                             acc_valid;
  logic                             acc_write;
  logic [31:0]                      acc_addr;
  // hits found by the matchers
  logic [USER_NUM-1:0]              user_wr_hit;
  logic [USER_NUM-1:0]              user_rd_hit;
  logic [PER_NUM-1:0]               per_wr_hit;
  logic [PER_NUM-1:0]               per_rd_hit;
  logic [PER_NUM-1:0][SUB_NUM-1:0]  per_sub_hot;

  modport src (output acc_valid, acc_write, acc_addr,
               input  user_wr_hit, user_rd_hit, per_wr_hit, per_rd_hit, per_sub_hot);
  modport user_m (input acc_valid, acc_write, acc_addr, output user_wr_hit, user_rd_hit);
  modport per_m (input acc_valid, acc_write, acc_addr, output per_wr_hit, per_rd_hit, per_sub_hot);

endinterface : maw_hit_if

// file: maw_user_match.sv
`timescale 1ns/10ps
module maw_user_match import maw_pkg::*; (
  // snooped access and hit results
  maw_hit_if.user_m                 hif,
  // region bounds and enables
  input  wire logic [USER_NUM-1:0][31:0] start_i,
  input  wire logic [USER_NUM-1:0][31:0] end_i,
  input  wire logic [USER_NUM-1:0]       wr_en_i,
  input  wire logic [USER_NUM-1:0]       rd_en_i
);

  logic [USER_NUM-1:0] in_rng;

  // inclusive byte compare; an end below the start simply never hits
  for (genvar g = 0; g < USER_NUM; g++) begin : g_rgn
    assign in_rng[g] = hif.acc_valid && (hif.acc_addr >= start_i[g]) && (hif.acc_addr <= end_i[g]);
    assign hif.user_wr_hit[g] = in_rng[g] && hif.acc_write && wr_en_i[g];
    assign hif.user_rd_hit[g] = in_rng[g] && !hif.acc_write && rd_en_i[g];
  end

endmodule : maw_user_match

// file: maw_periph_match.sv
`timescale 1ns/10ps
module maw_periph_match import maw_pkg::*; (
  // snooped access and hit results
  maw_hit_if.per_m                        hif,
  // subregion include masks and whole-region enables
  input  wire logic [PER_NUM-1:0][SUB_NUM-1:0] subregion_include_mask_i,
  input  wire logic [PER_NUM-1:0]              wr_en_i,
  input  wire logic [PER_NUM-1:0]              rd_en_i
);

  logic [PER_NUM-1:0]               in_rng;
  logic [PER_NUM-1:0]               any_sub;
  logic [SUB_IDX_W-1:0]             sub_idx;
  logic [PER_NUM-1:0][SUB_NUM-1:0]  sub_hot;

  // 4 kb slots, index from the address bits just above the slot offset
  assign sub_idx = hif.acc_addr[SUB_LSB +: SUB_IDX_W];

  for (genvar g = 0; g < PER_NUM; g++) begin : g_per
    assign in_rng[g] = hif.acc_valid && (hif.acc_addr >= PER_FIRST[g]) && (hif.acc_addr <= PER_LAST[g]);
    // excluded slots mask the hit away
    assign sub_hot[g] = in_rng[g] ? ((32'h00000001 << sub_idx) & subregion_include_mask_i[g]) : 32'h00000000;
    assign any_sub[g] = |sub_hot[g];
    // enables are per region only, not per slot
    assign hif.per_wr_hit[g]  = any_sub[g] && hif.acc_write && wr_en_i[g];
    assign hif.per_rd_hit[g]  = any_sub[g] && !hif.acc_write && rd_en_i[g];
    assign hif.per_sub_hot[g] = sub_hot[g];
  end

endmodule : maw_periph_match

// file: maw_top.sv
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
// Notes on behaviour
// - six watch regions: four programmable, two fixed in peripheral space
// - fixed regions span 0x40000000-0x4001ffff and 0x40020000-0x4003ffff
// - programmable bounds are byte exact and both ends count as inside
// - every region has its own write event and read event
// - fixed regions keep write-hit and read-hit subregion status masks
// - only cpu accesses into data ram or peripheral segments are watched
// - dma master accesses never raise watch events
// - an event shows two clock cycles after the matching access
// - each fixed region splits into 32 equal subregions, 0 to 31
// - all subregions excluded after reset; include mask bits add them
// - access to an excluded subregion raises no event
// - fixed regions have one read enable and one write enable each
// - programmable regions have read and write enables in the enable mask
// - set and clear aliases change only the enable bits written as one
// - each event routes to maskable irq or nmi, each separately enabled
// - enable mask at 0x510, set alias 0x514, clear alias 0x518
// - region n start at 0x600 plus 16n, end four bytes above
module maw_top import maw_pkg::*; (
  // clock and reset
  input  wire logic        REF_CLK_I,
  input  wire logic        RSTN_I,
  // avalon-mm register slave
  input  wire logic [11:0] AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  // snooped cpu system bus
  input  wire logic        CPU_VALID_I,
  input  wire logic        CPU_WRITE_I,
  input  wire logic [31:0] CPU_ADDR_I,
  input  wire logic        CPU_DMA_I,
  // event and interrupt outputs
  output logic [EV_NUM-1:0] EVENT_O,
  output logic             IRQ_O,
  output logic             NMI_O
);

  // register state
  logic [USER_NUM-1:0][31:0]        start_reg, start_next;
  logic [USER_NUM-1:0][31:0]        end_reg, end_next;
  logic [PER_NUM-1:0][SUB_NUM-1:0]  subregion_include_mask_reg, subregion_include_mask_next;
  logic [PER_NUM-1:0][SUB_NUM-1:0]  stat_wr_reg, stat_wr_next;
  logic [PER_NUM-1:0][SUB_NUM-1:0]  stat_rd_reg, stat_rd_next;
  logic [31:0]                      wen_reg, wen_next;
  logic [EV_NUM-1:0]                inten_reg, inten_next;
  logic [EV_NUM-1:0]                nmien_reg, nmien_next;
  logic [EV_NUM-1:0]                ev_reg, ev_next;
  logic [EV_NUM-1:0]                pulse_reg;
  logic                             ack_reg;
  logic [31:0]                      rdata_reg;
  // access pipeline
  logic                             acc_valid_reg;
  logic                             acc_write_reg;
  logic [31:0]                      acc_addr_reg;
  // decode wires
  logic                             wr_en;
  logic                             cpu_watched;
  logic                             in_ram_seg;
  logic                             in_per_seg;
  logic [31:0]                      be_mask;
  logic [31:0]                      wdata_m;
  logic [EV_NUM-1:0]                ev_set;
  logic [EV_NUM-1:0]                ev_sel;
  logic [USER_NUM-1:0]              start_sel;
  logic [USER_NUM-1:0]              end_sel;
  logic [PER_NUM-1:0]               subregion_include_mask_sel;
  logic [PER_NUM-1:0]               stat_wr_sel;
  logic [PER_NUM-1:0]               stat_rd_sel;
  logic [USER_NUM-1:0]              user_wr_en;
  logic [USER_NUM-1:0]              user_rd_en;
  logic [PER_NUM-1:0]               per_wr_en;
  logic [PER_NUM-1:0]               per_rd_en;
  logic                             sel_inten, sel_inten_set, sel_inten_clr;
  logic                             sel_nmien, sel_nmien_set, sel_nmien_clr;
  logic                             sel_wen, sel_wen_set, sel_wen_clr;
  logic [31:0]                      rd_mux;

  maw_hit_if hif ();

  // byte address of an event flag, user events first then peripheral ones
  function automatic logic [11:0] ev_ofs(input int e);
    if (e < EV_PER_BASE) begin
      return 12'(OFS_EV_USER + e * EV_STRIDE);
    end
    return 12'(OFS_EV_PER + (e - EV_PER_BASE) * EV_STRIDE);
  endfunction : ev_ofs

  // plain, set-alias or clear-alias update of an enable word
  function automatic logic [31:0] alias_upd(input logic [31:0] cur, input logic [31:0] wd,
                                            input logic sel_p, input logic sel_s, input logic sel_c);
    logic [31:0] r;
    r = cur;
    if (sel_p) begin
      r = (cur & ~be_mask) | wd;
    end else if (sel_s) begin
      r = cur | wd;
    end else if (sel_c) begin
      r = cur & ~wd;
    end
    return r;
  endfunction : alias_upd

  // byte-lane merge for plain word registers
  function automatic logic [31:0] be_merge(input logic [31:0] cur);
    return (cur & ~be_mask) | wdata_m;
  endfunction : be_merge

  // bus handshake: one wait state, then the access completes
  assign AVS_WAITREQUEST_O = (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
  assign wr_en             = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  assign AVS_READDATA_O    = rdata_reg;
  assign be_mask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
                    {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  assign wdata_m = AVS_WRITEDATA_I & be_mask;

  // fixed register selects
  assign sel_inten     = AVS_ADDRESS_I == OFS_INTEN;
  assign sel_inten_set = AVS_ADDRESS_I == OFS_INTEN_SET;
  assign sel_inten_clr = AVS_ADDRESS_I == OFS_INTEN_CLR;
  assign sel_nmien     = AVS_ADDRESS_I == OFS_NMIEN;
  assign sel_nmien_set = AVS_ADDRESS_I == OFS_NMIEN_SET;
  assign sel_nmien_clr = AVS_ADDRESS_I == OFS_NMIEN_CLR;
  assign sel_wen       = AVS_ADDRESS_I == OFS_WEN;
  assign sel_wen_set   = AVS_ADDRESS_I == OFS_WEN_SET;
  assign sel_wen_clr   = AVS_ADDRESS_I == OFS_WEN_CLR;

  // indexed register selects
  for (genvar g = 0; g < EV_NUM; g++) begin : g_ev_sel
    assign ev_sel[g] = AVS_ADDRESS_I == ev_ofs(g);
  end
  for (genvar g = 0; g < USER_NUM; g++) begin : g_user_sel
    assign start_sel[g] = AVS_ADDRESS_I == 12'(OFS_USER_START + g * REGION_STRIDE);
    assign end_sel[g]   = AVS_ADDRESS_I == 12'(OFS_USER_START + g * REGION_STRIDE + END_DELTA);
  end
  for (genvar g = 0; g < PER_NUM; g++) begin : g_per_sel
    assign subregion_include_mask_sel[g]    = AVS_ADDRESS_I == 12'(OFS_PER_CFG + g * REGION_STRIDE + SUBREGION_INCLUDE_MASK_DELTA);
    assign stat_wr_sel[g] = AVS_ADDRESS_I == 12'(OFS_SUBSTAT + g * 2 * EV_STRIDE);
    assign stat_rd_sel[g] = AVS_ADDRESS_I == 12'(OFS_SUBSTAT + g * 2 * EV_STRIDE + EV_STRIDE);
  end

  // read data; unmapped and reserved words read as zero
  function automatic logic [31:0] rd_word();
    logic [31:0] d;
    d = 32'h00000000;
    for (int e = 0; e < EV_NUM; e++) begin
      if (ev_sel[e]) d = {31'h00000000, ev_reg[e]};
    end
    for (int i = 0; i < USER_NUM; i++) begin
      if (start_sel[i]) d = start_reg[i];
      if (end_sel[i]) d = end_reg[i];
    end
    for (int j = 0; j < PER_NUM; j++) begin
      if (subregion_include_mask_sel[j]) d = subregion_include_mask_reg[j];
      if (stat_wr_sel[j]) d = stat_wr_reg[j];
      if (stat_rd_sel[j]) d = stat_rd_reg[j];
    end
    if (sel_inten || sel_inten_set || sel_inten_clr) d = {{(32-EV_NUM){1'b0}}, inten_reg};
    if (sel_nmien || sel_nmien_set || sel_nmien_clr) d = {{(32-EV_NUM){1'b0}}, nmien_reg};
    if (sel_wen || sel_wen_set || sel_wen_clr) d = wen_reg;
    return d;
  endfunction : rd_word

  // a process, not an assign: the function reads registers that are not its arguments
  always_comb rd_mux = rd_word();

  // access filter: cpu only, ram and peripheral segments only
  assign in_ram_seg  = (CPU_ADDR_I >= RAM_SEG_FIRST) && (CPU_ADDR_I <= RAM_SEG_LAST);
  assign in_per_seg  = (CPU_ADDR_I >= PER_SEG_FIRST) && (CPU_ADDR_I <= PER_SEG_LAST);
  assign cpu_watched = CPU_VALID_I && !CPU_DMA_I && (in_ram_seg || in_per_seg);

  // pipeline into the matchers
  assign hif.acc_valid = acc_valid_reg;
  assign hif.acc_write = acc_write_reg;
  assign hif.acc_addr  = acc_addr_reg;

  // enable mask fields
  for (genvar g = 0; g < USER_NUM; g++) begin : g_user_en
    assign user_wr_en[g] = wen_reg[2 * g];
    assign user_rd_en[g] = wen_reg[2 * g + 1];
  end
  for (genvar g = 0; g < PER_NUM; g++) begin : g_per_en
    assign per_wr_en[g] = wen_reg[WEN_PER_LSB + 2 * g];
    assign per_rd_en[g] = wen_reg[WEN_PER_LSB + 2 * g + 1];
  end

  maw_user_match u_user (
    .hif     (hif),
    .start_i (start_reg),
    .end_i   (end_reg),
    .wr_en_i (user_wr_en),
    .rd_en_i (user_rd_en)
  );

  maw_periph_match u_per (
    .hif     (hif),
    .subregion_include_mask_i  (subregion_include_mask_reg),
    .wr_en_i (per_wr_en),
    .rd_en_i (per_rd_en)
  );

  // event vector: even bit write, odd bit read
  for (genvar g = 0; g < USER_NUM; g++) begin : g_user_ev
    assign ev_set[2 * g]     = hif.user_wr_hit[g];
    assign ev_set[2 * g + 1] = hif.user_rd_hit[g];
  end
  for (genvar g = 0; g < PER_NUM; g++) begin : g_per_ev
    assign ev_set[EV_PER_BASE + 2 * g]     = hif.per_wr_hit[g];
    assign ev_set[EV_PER_BASE + 2 * g + 1] = hif.per_rd_hit[g];
  end

  // sticky flags; a hit in the clearing cycle wins over the write
  for (genvar g = 0; g < EV_NUM; g++) begin : g_ev_next
    assign ev_next[g] = ev_set[g] || ((wr_en && ev_sel[g] && AVS_BYTEENABLE_I[0]) ?
                                      AVS_WRITEDATA_I[0] : ev_reg[g]);
  end

  // config and status next values
  for (genvar g = 0; g < USER_NUM; g++) begin : g_user_next
    assign start_next[g] = (wr_en && start_sel[g]) ? be_merge(start_reg[g]) : start_reg[g];
    assign end_next[g]   = (wr_en && end_sel[g]) ? be_merge(end_reg[g]) : end_reg[g];
  end
  for (genvar g = 0; g < PER_NUM; g++) begin : g_per_next
    assign subregion_include_mask_next[g] = (wr_en && subregion_include_mask_sel[g]) ? be_merge(subregion_include_mask_reg[g]) : subregion_include_mask_reg[g];
    // zero bits written clear, new hits accumulate and win
    assign stat_wr_next[g] = (hif.per_wr_hit[g] ? hif.per_sub_hot[g] : 32'h00000000) |
                             ((wr_en && stat_wr_sel[g]) ? (stat_wr_reg[g] & (AVS_WRITEDATA_I | ~be_mask))
                                                        : stat_wr_reg[g]);
    assign stat_rd_next[g] = (hif.per_rd_hit[g] ? hif.per_sub_hot[g] : 32'h00000000) |
                             ((wr_en && stat_rd_sel[g]) ? (stat_rd_reg[g] & (AVS_WRITEDATA_I | ~be_mask))
                                                        : stat_rd_reg[g]);
  end

  // enable words with set and clear aliases
  assign wen_next   = WEN_MASK & alias_upd(wen_reg, wdata_m, wr_en && sel_wen,
                                           wr_en && sel_wen_set, wr_en && sel_wen_clr);
  assign inten_next = EV_NUM'(alias_upd({{(32-EV_NUM){1'b0}}, inten_reg}, wdata_m, wr_en && sel_inten,
                                        wr_en && sel_inten_set, wr_en && sel_inten_clr));
  assign nmien_next = EV_NUM'(alias_upd({{(32-EV_NUM){1'b0}}, nmien_reg}, wdata_m, wr_en && sel_nmien,
                                        wr_en && sel_nmien_set, wr_en && sel_nmien_clr));

  // interrupt routing from the sticky flags
  assign IRQ_O   = |(ev_reg & inten_reg);
  assign NMI_O   = |(ev_reg & nmien_reg);
  assign EVENT_O = pulse_reg;

  // bus answer registers
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h00000000;
    end else begin
      ack_reg   <= (AVS_READ_I || AVS_WRITE_I) && !ack_reg;
      rdata_reg <= (AVS_READ_I && !ack_reg) ? rd_mux : rdata_reg;
    end
  end

  // access capture: first of the two cycles to an event
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      acc_valid_reg <= 1'b0;
      acc_write_reg <= 1'b0;
      acc_addr_reg  <= 32'h00000000;
    end else begin
      acc_valid_reg <= cpu_watched;
      acc_write_reg <= CPU_WRITE_I;
      acc_addr_reg  <= CPU_ADDR_I;
    end
  end

  // second cycle: flags, pulses and status update
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      ev_reg      <= '0;
      pulse_reg   <= '0;
      stat_wr_reg <= '0;
      stat_rd_reg <= '0;
    end else begin
      ev_reg      <= ev_next;
      pulse_reg   <= ev_set;
      stat_wr_reg <= stat_wr_next;
      stat_rd_reg <= stat_rd_next;
    end
  end

  // software configuration
  always_ff @(posedge REF_CLK_I) begin
    if (!RSTN_I) begin
      start_reg <= {USER_NUM{ADDR_RESET}};
      end_reg   <= {USER_NUM{ADDR_RESET}};
      subregion_include_mask_reg  <= {PER_NUM{SUBREGION_INCLUDE_MASK_RESET}};
      wen_reg   <= WEN_RESET;
      inten_reg <= '0;
      nmien_reg <= '0;
    end else begin
      start_reg <= start_next;
      end_reg   <= end_next;
      subregion_include_mask_reg  <= subregion_include_mask_next;
      wen_reg   <= wen_next;
      inten_reg <= inten_next;
      nmien_reg <= nmien_next;
    end
  end

endmodule : maw_top

// file: maw_top_properties.sv
`timescale 1ns/10ps
module maw_top_checker import maw_pkg::*; (
  // clock and reset
  input wire logic              REF_CLK_I,
  input wire logic              RSTN_I,
  // register slave
  input wire logic [11:0]       AVS_ADDRESS_I,
  input wire logic              AVS_READ_I,
  input wire logic              AVS_WRITE_I,
  input wire logic [31:0]       AVS_WRITEDATA_I,
  input wire logic [3:0]        AVS_BYTEENABLE_I,
  input wire logic [31:0]       AVS_READDATA_O,
  input wire logic              AVS_WAITREQUEST_O,
  // snooped bus
  input wire logic              CPU_VALID_I,
  input wire logic              CPU_WRITE_I,
  input wire logic [31:0]       CPU_ADDR_I,
  input wire logic              CPU_DMA_I,
  // events and interrupts
  input wire logic [EV_NUM-1:0] EVENT_O,
  input wire logic              IRQ_O,
  input wire logic              NMI_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // qualified cpu accesses; the checker cannot see the bounds, so it bounds events by cause only
  wire acc    = CPU_VALID_I && !CPU_DMA_I && CPU_ADDR_I >= RAM_SEG_FIRST && CPU_ADDR_I <= PER_SEG_LAST;
  wire acc_w  = acc && CPU_WRITE_I;
  wire acc_r  = acc && !CPU_WRITE_I;
  wire per0   = acc && CPU_ADDR_I[31:17] == 15'h2000;
  wire per1   = acc && CPU_ADDR_I[31:17] == 15'h2001;
  wire reg_wr = AVS_WRITE_I && !AVS_WAITREQUEST_O;
  // events two cycles after their access
  seg_only_a: assert property (!acc |-> ##2 EVENT_O == '0) else $error("event without watched access");
  wr_only_a: assert property (!acc_w |-> ##2 (EVENT_O & 12'h555) == '0) else $error("write event without write");
  rd_only_a: assert property (!acc_r |-> ##2 (EVENT_O & 12'haaa) == '0) else $error("read event without read");
  per0_span_a: assert property (!per0 |-> ##2 EVENT_O[9:8] == 2'b00) else $error("region 0 event outside it");
  per1_span_a: assert property (!per1 |-> ##2 EVENT_O[11:10] == 2'b00) else $error("region 1 event outside it");
  // register slave handshake
  bus_wait_a: assert property ($rose(AVS_READ_I || AVS_WRITE_I) |-> AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
    else $error("wait state not exactly one");
  rdata_hold_a: assert property (!AVS_READ_I |=> $stable(AVS_READDATA_O)) else $error("read data moved");
  // interrupt lines follow flags or register writes
  irq_rise_a: assert property ($rose(IRQ_O) |-> $past(acc, 2) || $past(reg_wr)) else $error("irq without cause");
  irq_hold_a: assert property ($fell(IRQ_O) |-> $past(reg_wr)) else $error("irq dropped by itself");
  nmi_rise_a: assert property ($rose(NMI_O) |-> $past(acc, 2) || $past(reg_wr)) else $error("nmi without cause");
endmodule : maw_top_checker

bind maw_top maw_top_checker u_chk (.REF_CLK_I(REF_CLK_I), .RSTN_I(RSTN_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
  .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
  .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
  .CPU_VALID_I(CPU_VALID_I), .CPU_WRITE_I(CPU_WRITE_I), .CPU_ADDR_I(CPU_ADDR_I), .CPU_DMA_I(CPU_DMA_I),
  .EVENT_O(EVENT_O), .IRQ_O(IRQ_O), .NMI_O(NMI_O));

// file: maw_cpu_model.sv
`timescale 1ns/10ps
module maw_cpu_model (
  // clock
  input  wire logic   clk_i,
  // snooped access
  output logic        valid_o,
  output logic        write_o,
  output logic [31:0] addr_o,
  output logic        dma_o
);
  // quiet bus at time zero
  initial begin
    valid_o = 1'b0;
    write_o = 1'b0;
    addr_o  = 32'h0;
    dma_o   = 1'b0;
  end
  // one access for one cycle; idle write and address lines show the inverse so stale values never pass
  task automatic access(input logic w, input logic [31:0] a, input logic d);
    @(posedge clk_i);
    valid_o <= 1'b1;
    write_o <= w;
    addr_o  <= a;
    dma_o   <= d;
    @(posedge clk_i);
    valid_o <= 1'b0;
    write_o <= ~w;
    addr_o  <= ~a;
  endtask : access
endmodule : maw_cpu_model

// file: maw_top_tb.sv
`timescale 1ns/10ps
module maw_top_tb import maw_pkg::*;;
  // design inputs and outputs
  logic              clk = 1'b0;
  logic              rstn = 1'b0;
  logic [11:0]       avs_addr = 12'h0;
  logic              avs_rd = 1'b0;
  logic              avs_wr = 1'b0;
  logic [31:0]       avs_wdata = 32'h0;
  logic [31:0]       avs_rdata;
  logic              avs_wait, cpu_valid, cpu_write, cpu_dma, irq, nmi;
  logic [31:0]       cpu_addr;
  logic [EV_NUM-1:0] ev;
  // reference model
  logic [31:0]       m_start [4], m_end [4], m_subregion_include_mask [2], m_ss [4];
  logic [31:0]       m_wen, m_inten, m_nmien, seed, q;
  logic [11:0]       m_flag;
  logic [11:0]       ra [8] = '{12'h510, 12'h6c8, 12'h6d8, 12'h600, 12'h634, 12'h6c0, 12'h160, 12'h7fc};
  logic [31:0]       pa [6] = '{32'h40003000, 32'h40002ffc, 32'h40000000, 32'h4003f000, 32'h40020000, 32'h60000000};
  int                bad_count = 0, checked = 0, cycles = 0, n;

  always #12.5 clk = ~clk;
  // ceiling far above the few hundred cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      summarize();
    end
  end

  maw_top dut (.REF_CLK_I(clk), .RSTN_I(rstn), .AVS_ADDRESS_I(avs_addr), .AVS_READ_I(avs_rd), .AVS_WRITE_I(avs_wr),
    .AVS_WRITEDATA_I(avs_wdata), .AVS_BYTEENABLE_I(4'hf), .AVS_READDATA_O(avs_rdata), .AVS_WAITREQUEST_O(avs_wait),
    .CPU_VALID_I(cpu_valid), .CPU_WRITE_I(cpu_write), .CPU_ADDR_I(cpu_addr), .CPU_DMA_I(cpu_dma),
    .EVENT_O(ev), .IRQ_O(irq), .NMI_O(nmi));
  maw_cpu_model cpu (.clk_i(clk), .valid_o(cpu_valid), .write_o(cpu_write), .addr_o(cpu_addr), .dma_o(cpu_dma));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected event vector for one access
  function automatic logic [11:0] exp_ev(input logic w, input logic [31:0] a, input logic d);
    logic [11:0] e;
    int          b;
    e = '0;
    b = w ? 0 : 1;
    for (int j = 0; j < 4; j++)
      if (a >= m_start[j] && a <= m_end[j] && m_wen[2*j+b]) e[2*j+b] = 1'b1;
    for (int j = 0; j < 2; j++)
      if (a[31:17] == PER_FIRST[j][31:17] && m_subregion_include_mask[j][a[16:12]] && m_wen[24+2*j+b])
        e[8+2*j+b] = 1'b1;
    return (d || a < RAM_SEG_FIRST || a > PER_SEG_LAST) ? 12'h0 : e;
  endfunction : exp_ev

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one avalon transfer, held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_wr <= w;
    avs_rd <= !w;
    avs_addr <= a;
    avs_wdata <= d;
    @(posedge clk);
    while (avs_wait !== 1'b0) @(posedge clk);
    // the write lands and read data is taken at this same edge
    q = avs_rdata;
    avs_wr <= 1'b0;
    avs_rd <= 1'b0;
    avs_addr <= ~a;
    avs_wdata <= ~d;
  endtask : bus
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask : wr
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    check(q, exp);
  endtask : rd_chk
  // access, then compare the event pulse in the second cycle after it
  task automatic snoop(input logic w, input logic [31:0] a, input logic d);
    logic [11:0] e;
    e = exp_ev(w, a, d);
    cpu.access(w, a, d);
    @(posedge clk);
    @(negedge clk);
    check(ev, e);
    m_flag |= e;
    for (int k = 8; k < 12; k++) if (e[k]) m_ss[k-8][a[16:12]] = 1'b1;
    check(irq, |(m_flag & m_inten[11:0]));
    check(nmi, |(m_flag & m_nmien[11:0]));
  endtask : snoop
  task automatic reset_all();
    @(posedge clk);
    rstn <= 1'b0;
    repeat (5) @(posedge clk);
    rstn <= 1'b1;
    m_start = '{default: '0};
    m_end = '{default: '0};
    m_subregion_include_mask = '{default: '0};
    m_ss = '{default: '0};
    {m_wen, m_inten, m_nmien, m_flag} = '0;
  endtask : reset_all
  task automatic summarize();
    if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize

  // main sequence
  initial begin
    seed = 32'h44287a1a;
    reset_all();
    foreach (ra[i]) rd_chk(ra[i], 32'h0);
    // region 3 sits outside the watched segments on purpose; end never below start
    for (n = 0; n < 4; n++) begin
      seed = lfsr(seed);
      m_start[n] = (n == 3) ? 32'h00000100 : 32'h20000000 | (seed & 32'h00fffff0);
      m_end[n] = m_start[n] + seed[31:24];
      wr(12'(12'h600 + 16 * n), m_start[n]);
      wr(12'(12'h604 + 16 * n), m_end[n]);
      rd_chk(12'(12'h600 + 16 * n), m_start[n]);
      rd_chk(12'(12'h604 + 16 * n), m_end[n]);
    end
    seed = lfsr(seed);
    wr(12'h510, seed);
    rd_chk(12'h510, seed & WEN_MASK);
    wr(12'h510, 32'h00000055);
    wr(12'h514, 32'h050000a0);
    wr(12'h518, 32'h00000011);
    rd_chk(12'h514, 32'h050000e4);
    wr(12'h514, 32'hffffffff);
    m_wen = WEN_MASK;
    m_subregion_include_mask = '{32'h00000009, 32'h80000001};
    wr(12'h6c8, m_subregion_include_mask[0]);
    wr(12'h6d8, m_subregion_include_mask[1]);
    rd_chk(12'h6d8, m_subregion_include_mask[1]);
    m_inten = 32'h00000300;
    m_nmien = 32'h00000001;
    wr(12'h300, m_inten);
    wr(12'h320, m_nmien);
    for (n = 0; n < 8; n++) begin
      snoop(n[0], m_start[n/2] - 32'h1, 1'b0);
      snoop(n[0], m_start[n/2], 1'b0);
      snoop(n[0], m_end[n/2], 1'b0);
      snoop(n[0], m_end[n/2] + 32'h1, 1'b0);
    end
    for (n = 0; n < 12; n++) snoop(n[0], pa[n/2], 1'b0);
    snoop(1'b1, m_start[0], 1'b1);
    snoop(1'b0, pa[0], 1'b1);
    repeat (40) begin
      seed = lfsr(seed);
      snoop(seed[0], seed[2] ? {14'h1000, seed[19:2]} : {8'h20, seed[31:8]}, seed[3] & seed[4]);
    end
    for (n = 0; n < 12; n++) rd_chk(n < 8 ? 12'(12'h100 + 4 * n) : 12'(12'h140 + 4 * n), {31'h0, m_flag[n]});
    for (n = 0; n < 4; n++) rd_chk(12'(12'h400 + 4 * n), m_ss[n]);
    // clearing by writing zero, then the interrupt level must follow
    wr(12'h160, 32'h0);
    wr(12'h400, 32'h0);
    m_flag[8] = 1'b0;
    m_ss[0] = 32'h0;
    @(negedge clk);
    check(irq, |(m_flag & m_inten[11:0]));
    rd_chk(12'h400, 32'h0);
    wr(12'h518, 32'h0f0000ff);
    m_wen = 32'h0;
    snoop(1'b1, pa[0], 1'b0);
    snoop(1'b0, m_start[0], 1'b0);
    reset_all();
    rd_chk(12'h510, 32'h0);
    rd_chk(12'h6c8, 32'h0);
    summarize();
  end
endmodule : maw_top_tb
